// [logic/asi_regs.svh]
`ifndef ASI_REGS_SVH
`define ASI_REGS_SVH
`define ASI_OFS_ACON1 12'h0f4
`define ASI_OFS_ACON2 12'h0f8
`define ASI_OFS_REPORT 12'h140
`define ASI_OFS_CTRL 12'h144
`define ASI_MODE_LO 29
`define ASI_PEAK_LO 22
`define ASI_FUNC0_LO 18
`define ASI_TIME0_LO 16
`define ASI_SRC_ONE_LO 27
`define ASI_POL_ONE 21
`define ASI_DRVN_ONE 19
`define ASI_ACON2_MASK 32'hfffc0000
`define ASI_ACON2_RST 32'h000c0000
`define ASI_CTRL_MASK 32'h0000000f
`endif

// [logic/asi_pkg.sv]
package asi_pkg;
   typedef enum logic [1:0] {ASI_BUS_IDLE = 2'b01, ASI_BUS_ACK = 2'b10} asi_bus_t;
   typedef enum logic [1:0] {
      ASI_FN_OFF = 2'b00, ASI_FN_ONE = 2'b01, ASI_FN_TWO = 2'b10, ASI_FN_LOW = 2'b11
   } asi_func_t;
   typedef struct packed {
      asi_bus_t bus;
      logic [31:0] dat_o;
      logic [31:0] acon1;
      logic [31:0] acon2;
      logic [2:0] act_mode;
      logic [9:0] act_func;
      logic [3:0] dma_en;
      logic [3:0] flush;
      logic [31:0] report;
      logic [1:0] aclk_s;
      logic aclk_d;
      logic [1:0][1:0] bpin_s;
      logic [1:0][1:0] ln_s;
      logic [1:0] ln_d;
      logic [1:0][8:0] cnt;
      logic [1:0] lprev;
      logic [1:0] tick;
      logic [1:0] bck_o;
      logic [1:0] msb_pend;
      logic [1:0][4:0] mask;
      logic [1:0] first;
      logic [4:0] ws;
      logic [4:0] ext;
      logic [1:0] run;
      logic [1:0] ptr_rst;
   } asi_state_t;
endpackage

// [logic/asi_core.sv]
// Implementation choice: the Wishbone register port.
`include "asi_regs.svh"
module asi_core (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic aclk_pin,
   input wire logic bitclock_pin_one_i,
   output logic bitclock_pin_one_o,
   output logic bitclock_pin_one_oe,
   input wire logic bitclock_pin_two_i,
   output logic bitclock_pin_two_o,
   output logic bitclock_pin_two_oe,
   input wire logic [4:0] frame_line_i,
   output logic [4:0] frame_line_o,
   output logic [4:0] frame_line_oe,
   input wire logic smp_valid,
   input wire logic [4:0] smp_slot,
   input wire logic [7:0] smp_msb,
   input wire logic [1:0] seq_lsb,
   input wire logic [9:0] seq_next_mask,
   input wire logic [1:0] seq_next_first,
   input wire logic [1:0] seq_wrap,
   input wire logic [1:0] prot_hit,
   output logic [1:0] bit_tick,
   output logic [1:0] ptr_reset,
   output logic [1:0] port_run,
   output logic chain_mode,
   output logic [3:0] dma_flush
);
   import asi_pkg::*;

   asi_state_t s;
   asi_state_t n;

   function automatic logic [8:0] div_of(input logic [4:0] c);
      case (c)
         5'h03: div_of = 9'h002;
         5'h04: div_of = 9'h003;
         5'h05: div_of = 9'h004;
         5'h06: div_of = 9'h006;
         5'h07: div_of = 9'h008;
         5'h08: div_of = 9'h00c;
         5'h09: div_of = 9'h010;
         5'h0a: div_of = 9'h018;
         5'h0b: div_of = 9'h020;
         5'h0c: div_of = 9'h030;
         5'h0d: div_of = 9'h040;
         5'h0e: div_of = 9'h060;
         5'h0f: div_of = 9'h080;
         5'h10: div_of = 9'h0c0;
         5'h11: div_of = 9'h100;
         5'h12: div_of = 9'h180;
         default: div_of = 9'h000;
      endcase
   endfunction

   function automatic logic on_for(input logic [2:0] m, input logic i);
      on_for = i ? (m >= 3'h2) : (m != 3'h0 && m != 3'h2);
   endfunction

   function automatic logic [9:0] funcs_of(input logic [31:0] a);
      logic [9:0] f;
      f = '0;
      for (int x = 0; x < 5; x++) begin
         f[2*x +: 2] = a[`ASI_FUNC0_LO - 4*x +: 2];
      end
      return f;
   endfunction

   function automatic logic [31:0] wr_sel(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   logic [1:0] lvl;
   logic [1:0] tick;
   logic [1:0] evt;
   logic [1:0] pin_in;
   logic [8:0] dv;
   logic [4:0] src;
   logic [1:0] f;
   logic [1:0] tm;
   logic i;
   logic [7:0] mag;
   logic [31:0] setv;
   logic clr;
   logic [11:0] adr;

   always_comb begin
      n = s;
      lvl = '0;
      tick = '0;
      evt = '0;
      dv = '0;
      src = '0;
      f = '0;
      tm = '0;
      i = 1'b0;
      mag = '0;
      setv = '0;
      clr = 1'b0;
      adr = {wb_adr_i[11:2], 2'b00};
      // every pin passes two flops before use
      n.aclk_s = {s.aclk_s[0], aclk_pin};
      n.aclk_d = s.aclk_s[1];
      n.bpin_s[0] = {s.bpin_s[0][0], bitclock_pin_one_i};
      n.bpin_s[1] = {s.bpin_s[1][0], bitclock_pin_two_i};
      n.ln_s[0] = {s.ln_s[0][0], frame_line_i[0]};
      n.ln_s[1] = {s.ln_s[1][0], frame_line_i[4]};
      n.ln_d = {s.ln_s[1][1], s.ln_s[0][1]};
      pin_in[0] = s.bpin_s[0][1] ^ s.acon2[`ASI_POL_ONE];
      pin_in[1] = s.bpin_s[1][1] ^ s.acon2[`ASI_POL_ONE-1];
      for (int k = 0; k < 2; k++) begin
         src = s.acon2[`ASI_SRC_ONE_LO - 5*k +: 5];
         dv = div_of(src);
         if (s.aclk_s[1] && !s.aclk_d) begin
            n.cnt[k] = (s.cnt[k] + 9'h001 >= dv) ? 9'h000 : s.cnt[k] + 9'h001;
         end
         case (src)
            5'h00: lvl[k] = pin_in[k];
            5'h01: lvl[k] = pin_in[1-k];
            5'h02: lvl[k] = s.aclk_s[1];
            // reserved codes stop the clock
            default: lvl[k] = (dv != 9'h000) && (s.cnt[k] < (dv >> 1));
         endcase
         tick[k] = lvl[k] & ~s.lprev[k];
         n.lprev[k] = lvl[k];
         n.bck_o[k] = lvl[k] ^ s.acon2[`ASI_POL_ONE - k];
      end
      n.tick = tick;
      // rising input edges on lines 0 and 4 reset pointers
      evt[0] = (s.ln_s[0][1] & ~s.ln_d[0] & (s.act_func[1:0] == ASI_FN_OFF)) | seq_wrap[0];
      evt[1] = (s.ln_s[1][1] & ~s.ln_d[1] & (s.act_func[9:8] == ASI_FN_OFF)) | seq_wrap[1];
      // locked modes follow interface one's pointer
      if (s.act_mode >= 3'h4) begin
         evt[1] = evt[0];
      end
      n.ptr_rst = evt;
      for (int k = 0; k < 2; k++) begin
         if (!on_for(s.act_mode, k[0])) begin
            n.run[k] = 1'b0;
         end else if (evt[k]) begin
            n.run[k] = 1'b1;
         end
         if (tick[k]) begin
            n.msb_pend[k] = seq_lsb[k];
            if (seq_lsb[k]) begin
               n.mask[k] = seq_next_mask[5*k +: 5];
               n.first[k] = seq_next_first[k];
            end
         end
      end
      for (int x = 0; x < 5; x++) begin
         f = s.act_func[2*x +: 2];
         tm = s.acon1[`ASI_TIME0_LO - 4*x +: 2];
         i = (f == ASI_FN_TWO);
         if (f == ASI_FN_OFF || f == ASI_FN_LOW || !s.run[i]) begin
            n.ws[x] = 1'b0;
            n.ext[x] = 1'b0;
         end else if (tick[i]) begin
            n.ext[x] = 1'b0;
            case (tm)
               2'b00: if (seq_lsb[i]) n.ws[x] = seq_next_mask[5*i + x];
               2'b01: if (s.msb_pend[i]) n.ws[x] = s.mask[i][x];
               2'b10: n.ws[x] = seq_lsb[i] & seq_next_mask[5*i + x];
               // msb pulse, doubled in first slot
               default: begin
                  n.ws[x] = (s.msb_pend[i] & s.mask[i][x]) | s.ext[x];
                  n.ext[x] = s.msb_pend[i] & s.mask[i][x] & s.first[i];
               end
            endcase
         end
      end
      if (s.act_mode == 3'h0 || |prot_hit) begin
         n.act_mode = s.acon1[`ASI_MODE_LO +: 3];
         n.act_func = funcs_of(s.acon1);
      end
      // magnitude against limit, -128 always exceeds
      mag = smp_msb[7] ? 8'(-smp_msb) : smp_msb;
      if (smp_valid && mag > {1'b0, s.acon1[`ASI_PEAK_LO +: 7]}) begin
         setv = 32'h00000001 << smp_slot;
      end
      case (s.bus)
         ASI_BUS_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               n.bus = ASI_BUS_ACK;
               n.dat_o = '0;
               case (adr)
                  `ASI_OFS_ACON1: begin
                     n.dat_o = s.acon1;
                     if (wb_we_i) n.acon1 = wr_sel(s.acon1, wb_dat_i, wb_sel_i);
                  end
                  `ASI_OFS_ACON2: begin
                     n.dat_o = s.acon2;
                     if (wb_we_i) begin
                        n.acon2 = wr_sel(s.acon2, wb_dat_i, wb_sel_i) & `ASI_ACON2_MASK;
                     end
                  end
                  `ASI_OFS_REPORT: begin
                     n.dat_o = s.report;
                     clr = !wb_we_i;
                  end
                  `ASI_OFS_CTRL: begin
                     n.dat_o = {22'h000000, s.run, 1'b0, s.act_mode, s.dma_en};
                     if (wb_we_i) begin
                        n.dma_en = 4'(wr_sel({28'h0000000, s.dma_en}, wb_dat_i, wb_sel_i)
                                      & `ASI_CTRL_MASK);
                     end
                  end
                  default: n.dat_o = '0;
               endcase
            end
         end
         ASI_BUS_ACK: n.bus = ASI_BUS_IDLE;
         default: n.bus = ASI_BUS_IDLE;
      endcase
      // sticky bits, set wins over the read clear
      n.report = (clr ? 32'h00000000 : s.report) | setv;
      n.flush = s.dma_en & ~n.dma_en;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
         s.acon2 <= `ASI_ACON2_RST;
         s.bus <= ASI_BUS_IDLE;
      end else begin
         s <= n;
      end
   end

   assign wb_ack_o = (s.bus == ASI_BUS_ACK);
   assign wb_dat_o = s.dat_o;
   assign bitclock_pin_one_o = s.bck_o[0];
   assign bitclock_pin_two_o = s.bck_o[1];
   // pin drive bits are active low
   assign bitclock_pin_one_oe = ~s.acon2[`ASI_DRVN_ONE];
   assign bitclock_pin_two_oe = ~s.acon2[`ASI_DRVN_ONE-1];
   assign frame_line_o = s.ws;
   assign frame_line_oe = {|s.act_func[9:8], |s.act_func[7:6], |s.act_func[5:4],
                           |s.act_func[3:2], |s.act_func[1:0]};
   assign bit_tick = s.tick;
   assign ptr_reset = s.ptr_rst;
   assign port_run = s.run;
   assign chain_mode = (s.act_mode == 3'h7);
   assign dma_flush = s.flush;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_neg_max;
      smp_valid && smp_msb == 8'h80 |=> s.report[$past(smp_slot)];
   endproperty
   a_neg_max: assert property (p_neg_max) else $error("top byte -128 not flagged");

   property p_set;
      smp_valid && !smp_msb[7] && smp_msb[6:0] > s.acon1[28:22] |=> s.report[$past(smp_slot)];
   endproperty
   a_set: assert property (p_set) else $error("violation not recorded");

   property p_clr;
      s.bus == ASI_BUS_IDLE && wb_cyc_i && wb_stb_i && !wb_we_i && adr == `ASI_OFS_REPORT
         && !smp_valid |=> s.report == 32'h00000000 && wb_ack_o;
   endproperty
   a_clr: assert property (p_clr) else $error("report not cleared by read");

   property p_low;
      s.act_func[7:6] == ASI_FN_LOW |-> frame_line_oe[3] ##1 frame_line_o[3] == 1'b0;
   endproperty
   a_low: assert property (p_low) else $error("low line not driven low");

   property p_hold;
      s.act_mode != 3'h0 && prot_hit == 2'b00 |=> $stable(s.act_mode) && $stable(s.act_func);
   endproperty
   a_hold: assert property (p_hold) else $error("shadow leaked early");

   property p_imm;
      s.act_mode == 3'h0 |=> s.act_mode == $past(s.acon1[31:29]);
   endproperty
   a_imm: assert property (p_imm) else $error("idle load missed");

   property p_start;
      $rose(s.run[0]) |-> $past(evt[0]);
   endproperty
   a_start: assert property (p_start) else $error("started without pointer reset");

   property p_flush;
      s.dma_en[0] ##1 !s.dma_en[0] |-> dma_flush[0] ##1 !dma_flush[0];
   endproperty
   a_flush: assert property (p_flush) else $error("flush pulse wrong");

   c_viol: cover property (smp_valid ##1 s.report != 32'h00000000);
   c_run: cover property ($rose(s.run[1]));
   c_chain: cover property (chain_mode && bit_tick[0]);
endmodule

// [tb/asi_codec_model.sv]
module asi_codec_model (
   input wire logic clk_sys,
   input wire logic link_on,
   input wire logic sync_req,
   output logic aclk,
   output logic ext_bck,
   output logic sync_line
);
   timeunit 1ns;
   timeprecision 100ps;
   // master clock runs free, phase unrelated to clk_sys
   initial begin
      aclk = 1'b0;
      #37;
      forever #400 aclk = ~aclk;
   end
   // codec bit clock stands still while link_on is low
   initial begin
      ext_bck = 1'b0;
      forever begin
         #800;
         ext_bck = link_on ? ~ext_bck : 1'b0;
      end
   end
   // frame sync held 8 cycles so the synchroniser always sees it
   initial sync_line = 1'b0;
   always @(posedge sync_req) begin
      sync_line <= 1'b1;
      repeat (8) @(posedge clk_sys);
      sync_line <= 1'b0;
   end
endmodule

// [tb/tb_asi_core.sv]
`include "asi_regs.svh"
module tb_asi_core;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, smp_valid, link_on, sync_req;
   logic [11:0] wb_adr_i;
   logic [3:0] wb_sel_i, dma_flush, fl_seen;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic aclk, ext_bck, sync_line, b1_i, b1_o, b1_oe, b2_i, b2_o, b2_oe, chain_mode;
   logic [4:0] fl_i, fl_o, fl_oe, smp_slot;
   logic [7:0] smp_msb;
   logic [1:0] prot_hit, bit_tick, ptr_reset, port_run, ptr_seen;
   logic [1:0] seq_lsb, seq_next_first, seq_wrap;
   logic [9:0] seq_next_mask;
   int err_count, total_checks;
   // undriven lines 1..3 sit on pull-downs
   assign fl_i = (fl_oe & fl_o) | (~fl_oe & {sync_line, 3'b000, sync_line});
   assign b1_i = b1_oe ? b1_o : ext_bck;
   assign b2_i = b2_oe ? b2_o : ext_bck;
   asi_codec_model codec (.clk_sys(clk_sys), .link_on(link_on), .sync_req(sync_req),
      .aclk(aclk), .ext_bck(ext_bck), .sync_line(sync_line));
   asi_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .aclk_pin(aclk), .bitclock_pin_one_i(b1_i),
      .bitclock_pin_one_o(b1_o), .bitclock_pin_one_oe(b1_oe), .bitclock_pin_two_i(b2_i),
      .bitclock_pin_two_o(b2_o), .bitclock_pin_two_oe(b2_oe), .frame_line_i(fl_i),
      .frame_line_o(fl_o), .frame_line_oe(fl_oe), .smp_valid(smp_valid), .smp_slot(smp_slot),
      .smp_msb(smp_msb), .seq_lsb(seq_lsb), .seq_next_mask(seq_next_mask),
      .seq_next_first(seq_next_first), .seq_wrap(seq_wrap), .prot_hit(prot_hit),
      .bit_tick(bit_tick), .ptr_reset(ptr_reset),
      .port_run(port_run), .chain_mode(chain_mode), .dma_flush(dma_flush));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // pulses are collected so none is missed between bus cycles
   always @(posedge clk_sys) begin
      fl_seen <= rst_n ? (fl_seen | dma_flush) : 4'h0;
      ptr_seen <= rst_n ? (ptr_seen | ptr_reset) : 2'b00;
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic prot();
      @(posedge clk_sys);
      prot_hit <= 2'b01;
      @(posedge clk_sys);
      prot_hit <= 2'b00;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic t_reset();
      wb(0, `ASI_OFS_REPORT, 0);
      chk("report", q, 32'h0);
      wb(0, `ASI_OFS_ACON2, 0);
      chk("config2", q & `ASI_ACON2_MASK, `ASI_ACON2_RST);
      chk("pin one oe", 32'(b1_oe), 32'h0);
      wb(0, 12'h200, 0);
      chk("unmapped", q, 32'h0);
   endtask
   task automatic t_level(input logic [6:0] lim);
      logic [31:0] exp;
      logic [7:0] v;
      logic [7:0] mag;
      exp = 32'h0;
      wb(1, `ASI_OFS_ACON1, {3'h0, lim, 22'h0});
      wb(0, `ASI_OFS_REPORT, 0);
      for (int i = 0; i < 32; i++) begin
         v = 8'(lim) + 8'(i % 8) - 8'h03;
         v = (i % 16 > 7) ? -v : v;
         v = (i == 31) ? 8'h80 : v;
         mag = v[7] ? -v : v;
         exp[i] = exp[i] | (mag > {1'b0, lim});
         @(posedge clk_sys);
         smp_valid <= 1'b1;
         smp_slot <= 5'(i);
         smp_msb <= v;
         @(posedge clk_sys);
         smp_valid <= 1'b0;
      end
      wb(0, `ASI_OFS_REPORT, 0);
      chk("violations", q, exp);
      wb(0, `ASI_OFS_REPORT, 0);
      chk("cleared report", q, 32'h0);
   endtask
   task automatic t_dma();
      wb(1, `ASI_OFS_CTRL, 32'hf);
      wb(1, `ASI_OFS_CTRL, 32'h6);
      for (int n = 0; n < 20 && fl_seen === 4'h0; n++) @(posedge clk_sys);
      chk("flush", 32'(fl_seen), 32'h9);
   endtask
   task automatic t_lines();
      // line 0 and 4 inputs, 1 list one, 2 list two, 3 constant
      wb(1, `ASI_OFS_ACON1, 32'h0000_48c0);
      repeat (3) @(posedge clk_sys);
      chk("line oe", 32'(fl_oe), 32'h0e);
      chk("line level", 32'(fl_o), 32'h0);
      wb(1, `ASI_OFS_ACON1, 32'h2000_48c0);
      repeat (3) @(posedge clk_sys);
      chk("run early", 32'(port_run), 32'h0);
      @(posedge clk_sys);
      sync_req <= 1'b1;
      @(posedge clk_sys);
      sync_req <= 1'b0;
      for (int n = 0; n < 40 && ptr_seen[0] !== 1'b1; n++) @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
      chk("pointer reset", 32'(ptr_seen[0]), 32'h1);
      chk("run", 32'(port_run[0]), 32'h1);
      wb(1, `ASI_OFS_ACON1, 32'h2000_08c0);
      repeat (3) @(posedge clk_sys);
      chk("shadow oe", 32'(fl_oe), 32'h0e);
      prot();
      chk("loaded oe", 32'(fl_oe), 32'h0c);
      wb(1, `ASI_OFS_ACON1, 32'he000_08c0);
      prot();
      chk("chain", 32'(chain_mode), 32'h1);
      @(posedge clk_sys);
      seq_wrap <= 2'b01;
      @(posedge clk_sys);
      seq_wrap <= 2'b00;
      @(posedge clk_sys);
      chk("locked pointers", 32'(ptr_reset), 32'h3);
      wb(1, `ASI_OFS_ACON1, 32'h0);
      prot();
   endtask
   task automatic t_clock();
      logic [4:0] code [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h13};
      int exp [6] = '{20, 20, 40, 20, 10, 0};
      int cnt;
      link_on <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         wb(1, `ASI_OFS_ACON2, {code[k], code[k], 2'b00, 2'b11, 18'h0});
         repeat (20) @(posedge clk_sys);
         cnt = 0;
         for (int n = 0; n < 320; n++) begin
            @(posedge clk_sys);
            cnt += (bit_tick[0] === 1'b1);
         end
         // phase of the pin clocks allows one edge either way
         chk("ticks", 32'((cnt - exp[k] <= 1 && exp[k] - cnt <= 1) ? exp[k] : cnt),
            32'(exp[k]));
      end
      // interface two inverted and not driven, same divider, so the two outputs stand opposite at a tick
      wb(1, `ASI_OFS_ACON2, {5'h03, 5'h03, 2'b01, 2'b01, 18'h0});
      repeat (2) @(posedge clk_sys);
      chk("pin oe", 32'({b1_oe, b2_oe}), 32'h2);
      do @(posedge clk_sys); while (bit_tick[0] !== 1'b1);
      chk("bit clock out", 32'({b1_o, b2_o}), 32'h2);
      link_on <= 1'b0;
   endtask
   task automatic t_frame();
      // lines 0..3 on list one, timings 00, 01, 10, 11; ctl is lsb and first
      logic [1:0] ctl [5] = '{2'b11, 2'b00, 2'b00, 2'b10, 2'b00};
      logic [3:0] want [5] = '{4'h5, 4'hb, 4'hb, 4'h2, 4'h0};
      wb(1, `ASI_OFS_ACON2, {5'h02, 5'h02, 2'b00, 2'b11, 18'h0});
      wb(1, `ASI_OFS_ACON1, 32'h2004_5670);
      @(posedge clk_sys);
      seq_wrap <= 2'b01;
      @(posedge clk_sys);
      seq_wrap <= 2'b00;
      // align so every setting stands a whole bit before its tick
      do @(posedge clk_sys); while (bit_tick[0] !== 1'b1);
      for (int k = 0; k < 5; k++) begin
         seq_lsb <= {1'b0, ctl[k][1]};
         seq_next_first <= {1'b0, ctl[k][0]};
         seq_next_mask <= (k == 0) ? 10'h00f : 10'h000;
         do @(posedge clk_sys); while (bit_tick[0] !== 1'b1);
         chk("frame lines", 32'(fl_o[3:0]), 32'(want[k]));
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk_sys);
      err_count++;
      end_sim();
   end
   initial begin
      {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, smp_valid, link_on, sync_req} = 7'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i, smp_slot, smp_msb, prot_hit} = '0;
      {seq_lsb, seq_next_first, seq_wrap, seq_next_mask} = '0;
      err_count = 0;
      total_checks = 0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_level(7'h00);
      t_level(7'h0a);
      t_level(7'h7f);
      // output dma enabled before the interface starts
      t_dma();
      t_lines();
      t_clock();
      t_frame();
      end_sim();
   end
endmodule
